// ### design/timer_counter.sv
/*
 * 8-bit up-counting timer/counter with prescaled internal source,
 * external falling-edge event source, double-buffered auto-reload,
 * divide-by-two buzzer toggle output and PWM output, reached over an
 * Avalon-MM slave with waitrequest.
 * Assumes all inputs synchronous to sys_clk_i except the event pin,
 * which is synchronised here; sys_clk_i is the oscillator clock and
 * the instruction clock is a quarter of it.
 */
//
// Behaviour
// - Slow source: rate 000 gives cpu clock/256, halving to /2 at 111.
// - Fast source: rate 000 gives oscillator/128, down to /1 at 111.
// - Mode bit 7 stops the counter at 0, lets it count at 1.
// - External source: event counting, rate and fast select ignored.
// - External source: shared pin interrupt flag held at zero.
// - PWM boundary by reload and toggle bits: 256, 64, 32, 16.
// - Outside PWM the boundary is 256: overflow when the counter counts on from FF.
// - Auto-reload copies the holding reload value into counter on overflow.
// - Reload writes go to a holding buffer, active at next overflow.
// - PWM mode always reloads; reload bit only picks boundary.
// - Toggle enable outside PWM drives half overflow rate square wave, takes pin.
// - Clearing run stops counting, toggle output and PWM output.
// - Overflow keeps counting and sets the timer interrupt flag.
// - Event mode advances on each falling edge of the event pin.
// - PWM output high while counter below reference, low otherwise.
`timescale 1ns/1ps
module timer_counter
(
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic [timer_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [timer_pkg::BE_W-1:0] avs_byteenable_i,
   input wire logic [timer_pkg::DATA_W-1:0] avs_writedata_i,
   output logic [timer_pkg::DATA_W-1:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic event_input_pin_i,
   output logic toggle_output_o,
   output logic pwm_output_o,
   output logic pin_function_o,
   output logic irq_o
);
   import timer_pkg::*;

   // ************************************************
   // Declarations
   // ************************************************
   logic [7:0] mode_q;
   logic [7:0] t0_mode_q;
   logic [7:0] count_q;
   logic [7:0] count_d;
   logic [7:0] holding_q;
   logic [7:0] active_q;
   logic [IRQ_W-1:0] status_q;
   logic [IRQ_W-1:0] status_d;
   logic [IRQ_W-1:0] mask_q;
   logic [PRE_W-1:0] pre_q;
   logic [PRE_W-1:0] pre_mask;
   logic [3:0] shift;
   logic [2:0] rate;
   logic tick;
   logic sync1_q;
   logic sync2_q;
   logic sync3_q;
   logic fall;
   logic run;
   logic ext_src;
   logic aload;
   logic tout;
   logic pwm_en;
   logic fast;
   logic reload_on;
   logic [7:0] bound;
   logic count_en;
   logic overflow;
   logic wait_q;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;
   logic [7:0] idx;
   logic req;
   logic take_wr;
   logic byte0_wr;
   logic toggle_q;
   logic pwm_q;
   logic pin_q;
   logic irq_q;

   // ************************************************
   // Mode field decode
   // ************************************************
   assign run = mode_q[MODE_RUN_BIT];
   assign rate = mode_q[MODE_RATE_LSB +: MODE_RATE_W];
   assign ext_src = mode_q[MODE_EXT_BIT];
   assign aload = mode_q[MODE_ALOAD_BIT];
   assign tout = mode_q[MODE_TOUT_BIT];
   assign pwm_en = mode_q[MODE_PWM_BIT];
   assign fast = t0_mode_q[T0_FAST_BIT];
   assign reload_on = aload | pwm_en;

   // ************************************************
   // Bus request decode
   // ************************************************
   assign idx = avs_address_i[ADDR_W-1:2];
   assign req = avs_read_i | avs_write_i;
   // Write lands at the edge where waitrequest is seen low
   assign take_wr = avs_write_i & ~wait_q;
   assign byte0_wr = take_wr & avs_byteenable_i[0];

   // ************************************************
   // Prescaler
   // ************************************************
   always_comb
   begin
      if (fast)
      begin
         shift = FAST_TOP_SHIFT - {1'b0, rate};
      end
      else
      begin
         shift = CPU_DIV_SHIFT + SLOW_TOP_SHIFT - {1'b0, rate};
      end
   end

   assign pre_mask = PRE_W'((32'h1 << shift) - 32'h1);
   // Single-cycle enable, no derived clock
   assign tick = (pre_q & pre_mask) == pre_mask;

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         pre_q <= '0;
      end
      else
      begin
         pre_q <= pre_q + PRE_W'(1);
      end
   end

   // ************************************************
   // Event pin synchroniser and falling-edge detect
   // ************************************************
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
         sync3_q <= 1'b1;
      end
      else
      begin
         sync1_q <= event_input_pin_i;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   assign fall = sync3_q & ~sync2_q;

   // ************************************************
   // Count enable and overflow
   // ************************************************
   // Rate and fast select only reach the internal branch
   assign count_en = run & (ext_src ? fall : tick);

   always_comb
   begin
      if (!pwm_en)
      begin
         bound = BOUND_256;
      end
      else
      begin
         case ({aload, tout})
            2'b00: bound = BOUND_256;
            2'b01: bound = BOUND_64;
            2'b10: bound = BOUND_32;
            default: bound = BOUND_16;
         endcase
      end
   end

   assign overflow = count_en & ((count_q & bound) == bound);

   always_comb
   begin
      if (byte0_wr && idx == IDX_COUNT)
      begin
         count_d = avs_writedata_i[7:0];
      end
      else if (overflow && reload_on)
      begin
         count_d = holding_q;
      end
      else if (count_en)
      begin
         count_d = count_q + 8'h01;
      end
      else
      begin
         count_d = count_q;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         count_q <= COUNT_RESET;
      end
      else
      begin
         count_q <= count_d;
      end
   end

   // ************************************************
   // Reload double buffer
   // ************************************************
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         holding_q <= RELOAD_RESET;
      end
      else if (byte0_wr && idx == IDX_RELOAD)
      begin
         holding_q <= avs_writedata_i[7:0];
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         active_q <= RELOAD_RESET;
      end
      else if (overflow)
      begin
         active_q <= holding_q;
      end
   end

   // ************************************************
   // Mode registers
   // ************************************************
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         mode_q <= MODE_RESET;
      end
      else if (byte0_wr && idx == IDX_TIMER_MODE)
      begin
         mode_q <= avs_writedata_i[7:0];
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         t0_mode_q <= T0_RESET;
      end
      else if (byte0_wr && idx == IDX_TIMER0_MODE)
      begin
         t0_mode_q <= avs_writedata_i[7:0];
      end
   end

   // ************************************************
   // Buzzer and PWM outputs
   // ************************************************
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         toggle_q <= 1'b0;
      end
      else if (!run || !tout || pwm_en)
      begin
         toggle_q <= 1'b0;
      end
      else if (overflow)
      begin
         toggle_q <= ~toggle_q;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         pwm_q <= 1'b0;
      end
      else
      begin
         pwm_q <= run & pwm_en & (count_q < active_q);
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         pin_q <= 1'b0;
      end
      else
      begin
         // Shared pin leaves general-purpose use
         pin_q <= pwm_en | tout;
      end
   end

   // ************************************************
   // Interrupt status and mask
   // ************************************************
   always_comb
   begin
      status_d = status_q;
      if (take_wr && idx == IDX_IRQ_STATUS)
      begin
         status_d = status_q & ~avs_writedata_i[IRQ_W-1:0];
      end
      // Set wins over a clear in the same cycle
      if (overflow)
      begin
         status_d[IRQ_TIMER_BIT] = 1'b1;
      end
      if (fall && !ext_src)
      begin
         status_d[IRQ_SHARED_BIT] = 1'b1;
      end
      if (ext_src)
      begin
         status_d[IRQ_SHARED_BIT] = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         status_q <= IRQ_RESET;
      end
      else
      begin
         status_q <= status_d;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         mask_q <= IRQ_RESET;
      end
      else if (take_wr && idx == IDX_IRQ_MASK)
      begin
         mask_q <= avs_writedata_i[IRQ_W-1:0];
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         irq_q <= 1'b0;
      end
      else
      begin
         irq_q <= |(status_d & mask_q);
      end
   end

   // ************************************************
   // Bus slave: one wait cycle, then answer
   // ************************************************
   always_comb
   begin
      rdata_d = '0;
      if (idx == IDX_TIMER_MODE)
      begin
         rdata_d[7:0] = mode_q;
      end
      else if (idx == IDX_TIMER0_MODE)
      begin
         rdata_d[7:0] = t0_mode_q;
      end
      else if (idx == IDX_COUNT)
      begin
         rdata_d[7:0] = count_q;
      end
      else if (idx == IDX_IRQ_STATUS)
      begin
         rdata_d[IRQ_W-1:0] = status_q;
      end
      else if (idx == IDX_IRQ_MASK)
      begin
         rdata_d[IRQ_W-1:0] = mask_q;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         wait_q <= 1'b1;
      end
      else
      begin
         wait_q <= ~(req & wait_q);
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         rdata_q <= '0;
      end
      else if (avs_read_i && wait_q)
      begin
         rdata_q <= rdata_d;
      end
   end

   // ************************************************
   // Outputs
   // ************************************************
   assign avs_readdata_o = rdata_q;
   assign avs_waitrequest_o = wait_q;
   assign toggle_output_o = toggle_q;
   assign pwm_output_o = pwm_q;
   assign pin_function_o = pin_q;
   assign irq_o = irq_q;

endmodule

// ### design/timer_pkg.sv
/*
 * Constants for the 8-bit timer/counter with buzzer and PWM outputs:
 * register indices, field positions, reset values, boundary masks and
 * prescaler shifts.
 * Assumes byte address = 4 * register index on a 32-bit Avalon-MM bus.
 */
package timer_pkg;

   // ************************************************
   // Bus geometry
   // ************************************************
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam int BE_W = 4;

   // ************************************************
   // Register indices (byte address is four times these)
   // ************************************************
   localparam logic [7:0] IDX_TIMER0_MODE = 8'hD8;
   localparam logic [7:0] IDX_TIMER_MODE = 8'hDC;
   localparam logic [7:0] IDX_COUNT = 8'hDD;
   localparam logic [7:0] IDX_RELOAD = 8'hDE;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'hE0;
   localparam logic [7:0] IDX_IRQ_MASK = 8'hE1;

   // ************************************************
   // Field positions
   // ************************************************
   localparam int MODE_RUN_BIT = 7;
   localparam int MODE_RATE_LSB = 4;
   localparam int MODE_RATE_W = 3;
   localparam int MODE_EXT_BIT = 3;
   localparam int MODE_ALOAD_BIT = 2;
   localparam int MODE_TOUT_BIT = 1;
   localparam int MODE_PWM_BIT = 0;
   localparam int T0_FAST_BIT = 3;
   localparam int IRQ_TIMER_BIT = 0;
   localparam int IRQ_SHARED_BIT = 1;
   localparam int IRQ_W = 2;

   // ************************************************
   // Reset values
   // ************************************************
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] T0_RESET = 8'h00;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] RELOAD_RESET = 8'h00;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

   // ************************************************
   // Overflow boundaries as counter masks
   // ************************************************
   localparam logic [7:0] BOUND_256 = 8'hFF;
   localparam logic [7:0] BOUND_64 = 8'h3F;
   localparam logic [7:0] BOUND_32 = 8'h1F;
   localparam logic [7:0] BOUND_16 = 8'h0F;

   // ************************************************
   // Prescaler: system clock is the oscillator clock
   // ************************************************
   localparam int PRE_W = 10;
   localparam logic [3:0] FAST_TOP_SHIFT = 4'h7;
   localparam logic [3:0] CPU_DIV_SHIFT = 4'h2;
   localparam logic [3:0] SLOW_TOP_SHIFT = 4'h8;

endpackage

// ### tb/event_source.sv
/*
 * Far-side model: drives falling edges on the event pin on request.
 * Assumes start_i is a one-cycle pulse; the pin idles high (pull-up).
 */
`timescale 1ns/1ps
module event_source
(
   input wire logic sys_clk_i,
   input wire logic start_i,
   input wire logic [3:0] pulses_i,
   output logic event_input_pin_o,
   output logic busy_o
);
   initial
   begin
      event_input_pin_o = 1'b1;
      busy_o = 1'b0;
   end
   always
   begin
      do @(posedge sys_clk_i); while (!start_i);
      busy_o <= 1'b1;
      repeat (pulses_i)
      begin
         repeat (4) @(posedge sys_clk_i);
         event_input_pin_o <= 1'b0;
         repeat (4) @(posedge sys_clk_i);
         event_input_pin_o <= 1'b1;
      end
      busy_o <= 1'b0;
   end
endmodule

// ### tb/timer_counter_asserts.sv
/*
 * Port checker for timer_counter, mirroring mode and mask writes.
 * Assumes it is bound into timer_counter.
 */
`timescale 1ns/1ps
module timer_counter_asserts
(
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic [timer_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [timer_pkg::BE_W-1:0] avs_byteenable_i,
   input wire logic [timer_pkg::DATA_W-1:0] avs_writedata_i,
   input wire logic [timer_pkg::DATA_W-1:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic toggle_output_o,
   input wire logic pwm_output_o,
   input wire logic pin_function_o,
   input wire logic irq_o
);
   import timer_pkg::*;
   logic [7:0] m_q;
   logic [7:0] k_q;
   logic [1:0] s_q;
   logic [7:0] idx;
   logic wd;
   assign idx = avs_address_i[9:2];
   assign wd = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   // ****
   // Mirror of mode and mask, settle counter
   // ****
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         m_q <= 8'h00;
         k_q <= 8'h00;
         s_q <= 2'h0;
      end
      else
      begin
         if (wd && idx == IDX_TIMER_MODE)
            m_q <= avs_writedata_i[7:0];
         if (wd && idx == IDX_IRQ_MASK)
            k_q <= avs_writedata_i[7:0];
         if (wd)
            s_q <= 2'h0;
         else if (s_q != 2'h3)
            s_q <= s_q + 2'h1;
      end
   end
   property p_wait_ans;
      (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
   endproperty
   a_wait_ans: assert property (p_wait_ans)
      else $error("request not answered after one wait state");
   property p_wait_one;
      !avs_waitrequest_o |=> avs_waitrequest_o;
   endproperty
   a_wait_one: assert property (p_wait_one)
      else $error("waitrequest low for more than one cycle");
   property p_rd_reload;
      avs_read_i && !avs_waitrequest_o && idx == IDX_RELOAD
         |-> avs_readdata_o == 32'h0;
   endproperty
   a_rd_reload: assert property (p_rd_reload)
      else $error("write-only reload read nonzero");
   property p_stop;
      s_q == 2'h3 && !m_q[7] |-> !toggle_output_o && !pwm_output_o;
   endproperty
   a_stop: assert property (p_stop)
      else $error("output active while stopped");
   property p_tog;
      s_q == 2'h3 && toggle_output_o |-> m_q[7] && m_q[1] && !m_q[0];
   endproperty
   a_tog: assert property (p_tog)
      else $error("toggle output high while not enabled");
   property p_pwm;
      s_q == 2'h3 && pwm_output_o |-> m_q[7] && m_q[0];
   endproperty
   a_pwm: assert property (p_pwm)
      else $error("pwm output high outside pwm mode");
   property p_pin;
      s_q == 2'h3 |-> pin_function_o == (m_q[0] || m_q[1]);
   endproperty
   a_pin: assert property (p_pin)
      else $error("pin function does not follow output enables");
   property p_irq_mask;
      s_q == 2'h3 && k_q[1:0] == 2'h0 |-> !irq_o;
   endproperty
   a_irq_mask: assert property (p_irq_mask)
      else $error("interrupt raised with all sources masked");
endmodule
bind timer_counter timer_counter_asserts chk_u (.sys_clk_i, .reset_i,
   .avs_address_i, .avs_read_i, .avs_write_i, .avs_byteenable_i,
   .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
   .toggle_output_o, .pwm_output_o, .pin_function_o, .irq_o);

// ### tb/timer_counter_tb.sv
/*
 * Self-checking bench for timer_counter over its Avalon-MM port.
 * Assumes event_source as the pin driver and the bound checker.
 */
`timescale 1ns/1ps
module timer_counter_tb;
   import timer_pkg::*;
   logic sys_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [ADDR_W-1:0] adr = '0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [DATA_W-1:0] wdat = '0;
   logic [DATA_W-1:0] rdat;
   logic wait_o, tog, pwm, pin, irq, ev, ev_busy, v;
   logic ev_go = 1'b0;
   logic [3:0] ev_n = 4'h0;
   logic [31:0] q;
   int err_total = 0;
   int tests_run = 0;
   int i, n, div;
   logic [7:0] md [0:6] = '{8'h04, 8'h00, 8'h02, 8'h01, 8'h03, 8'h05, 8'h07};
   logic [7:0] st [0:6] = '{8'hFE, 8'hFE, 8'h3E, 8'hFE, 8'h3E, 8'h1E, 8'h0E};
   logic [7:0] ex [0:6] = '{8'h56, 8'h06, 8'h46, 8'h56, 8'h56, 8'h56, 8'h56};
   logic [7:0] ix [0:6] = '{8'hD8, 8'hDC, 8'hDD, 8'hDE, 8'hE0, 8'hE1, 8'hD9};
   always #50 sys_clk_i = ~sys_clk_i;
   timer_counter dut_u
   (
      .sys_clk_i, .reset_i, .avs_address_i(adr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_byteenable_i(4'hF), .avs_writedata_i(wdat),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o),
      .event_input_pin_i(ev), .toggle_output_o(tog), .pwm_output_o(pwm),
      .pin_function_o(pin), .irq_o(irq)
   );
   event_source ev_u
   (
      .sys_clk_i, .start_i(ev_go), .pulses_i(ev_n),
      .event_input_pin_o(ev), .busy_o(ev_busy)
   );
   // ****
   // Tasks
   // ****
   task automatic stop_test;
      $display("mismatches %0d of %0d compares", err_total, tests_run);
      if (err_total == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e)
      begin
         err_total++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] x,
      input logic [31:0] d);
      int k;
      @(posedge sys_clk_i);
      adr <= {x, 2'h0};
      wr <= w;
      rd <= !w;
      wdat <= d;
      k = 0;
      // Waitrequest and read data sampled at the rising edge
      do
      begin
         @(posedge sys_clk_i);
         k++;
      end
      while (wait_o !== 1'b0 && k < 20);
      if (wait_o !== 1'b0)
      begin
         err_total++;
         stop_test;
      end
      else
      begin
         q = rdat;
         wr <= 1'b0;
         rd <= 1'b0;
      end
   endtask
   task automatic wreg(input logic [7:0] x, input logic [31:0] d);
      acc(1'b1, x, d);
   endtask
   task automatic rchk(input logic [7:0] x, input logic [31:0] e);
      acc(1'b0, x, 32'h0);
      chk(q, e);
   endtask
   task automatic gap(input int c);
      repeat (c) @(posedge sys_clk_i);
   endtask
   task automatic pulses(input logic [3:0] c);
      int k;
      ev_n <= c;
      ev_go <= 1'b1;
      @(posedge sys_clk_i);
      ev_go <= 1'b0;
      k = 0;
      do
      begin
         @(negedge sys_clk_i);
         k++;
      end
      while (ev_busy !== 1'b0 && k < 200);
      if (ev_busy !== 1'b0)
      begin
         err_total++;
         stop_test;
      end
      else
      begin
         gap(6);
      end
   endtask
   // ****
   // Main sequence
   // ****
   initial
   begin
      gap(2);
      reset_i <= 1'b0;
      wreg(8'hD9, 32'hFF);
      for (i = 0; i < 7; i++)
         rchk(ix[i], 32'h0);
      wreg(8'hDC, 32'h7E);
      rchk(8'hDC, 32'h7E);
      for (i = 0; i < 16; i++)
      begin
         div = (i < 8) ? 1 << (10 - i) : 1 << (15 - i);
         wreg(8'hD8, (i < 8) ? 32'h0 : 32'h8);
         wreg(8'hDC, (i % 8) << 4);
         wreg(8'hDD, 32'h0);
         wreg(8'hDC, 32'h80 | ((i % 8) << 4));
         gap(4 * div - 3);
         wreg(8'hDC, 32'h0);
         rchk(8'hDD, 32'h4);
      end
      wreg(8'hE1, 32'h1);
      for (i = 0; i < 7; i++)
      begin
         wreg(8'hDC, 32'h0);
         wreg(8'hDD, st[i]);
         wreg(8'hDE, 32'h50);
         wreg(8'hE0, 32'h3);
         wreg(8'hDC, 32'hF0 | md[i]);
         gap(5);
         wreg(8'hDC, 32'h0);
         rchk(8'hDD, ex[i]);
         rchk(8'hE0, (md[i] == 8'h02) ? 32'h0 : 32'h1);
         chk(irq, (md[i] == 8'h02) ? 32'h0 : 32'h1);
      end
      wreg(8'hE0, 32'h1);
      gap(2);
      rchk(8'hE0, 32'h0);
      chk(irq, 32'h0);
      wreg(8'hDD, 32'h0);
      wreg(8'hDE, 32'h8);
      wreg(8'hDC, 32'hF7);
      gap(10);
      @(negedge sys_clk_i);
      chk(pwm, 32'h1);
      gap(30);
      @(negedge sys_clk_i);
      chk(pwm, 32'h0);
      wreg(8'hDC, 32'h0);
      wreg(8'hDD, 32'h0);
      wreg(8'hDE, 32'hF0);
      wreg(8'hDC, 32'hF6);
      gap(300);
      @(negedge sys_clk_i);
      v = tog;
      n = 0;
      repeat (64)
      begin
         @(negedge sys_clk_i);
         if (tog !== v)
            n++;
         v = tog;
      end
      chk(n, 32'h4);
      chk(pin, 32'h1);
      wreg(8'hDC, 32'h06);
      gap(3);
      chk(tog, 32'h0);
      wreg(8'hDC, 32'h0);
      wreg(8'hDD, 32'h0);
      // Both sources unmasked so the shared pin flag reaches irq
      wreg(8'hE1, 32'h3);
      wreg(8'hE0, 32'h3);
      pulses(4'h3);
      rchk(8'hE0, 32'h2);
      chk(irq, 32'h1);
      wreg(8'hE0, 32'h3);
      wreg(8'hDC, 32'hF8);
      pulses(4'h5);
      wreg(8'hDC, 32'h0);
      rchk(8'hDD, 32'h5);
      rchk(8'hE0, 32'h0);
      chk(irq, 32'h0);
      stop_test;
   end
endmodule
